// ---- logic/esp_chan.sv ----
// one output channel: enable-code handling and pause/resume of auto switching
`timescale 1ns/100ps
`default_nettype none
module esp_chan (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // enable nibble, valid only while process mode
  input wire logic [3:0] code,
  input wire logic code_valid,
  // channel state
  output logic auto_run_q,
  output logic nozzle_q,
  output logic out_level_q,
  output logic out_forced_q,
  output logic discard_q
);
  import esp_pkg::*;

  esp_mode_t mode;
  logic armed_q;

  assign mode = esp_decode(code);

  // armed survives nozzle and force codes so a later no-enable still discards; only no-enable clears it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      discard_q <= 1'b0;
      if (code_valid) begin
        if (mode == ESP_MODE_OFF) begin
          armed_q <= 1'b0; // RULE7
          discard_q <= armed_q; // RULE7
        end else if (mode == ESP_MODE_AUTO) begin
          armed_q <= 1'b1; // RULE8
        end
      end
    end
  end

  // run state follows the code; nozzle and force codes interrupt without disarming
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      auto_run_q <= 1'b0;
      nozzle_q <= 1'b0;
      out_level_q <= 1'b0;
      out_forced_q <= 1'b0;
    end else if (code_valid) begin
      auto_run_q <= (mode == ESP_MODE_AUTO); // RULE8 RULE9
      nozzle_q <= (mode == ESP_MODE_NOZZLE); // RULE9
      out_forced_q <= (mode == ESP_MODE_HIGH) || (mode == ESP_MODE_LOW); // RULE10
      out_level_q <= (mode == ESP_MODE_HIGH); // RULE10
    end
  end
endmodule // esp_chan
`default_nettype wire

// ---- logic/esp_coupler.sv ----
// coupler end: ahb-lite registers drive the output image and capture the input image
`timescale 1ns/100ps
`default_nettype none
module esp_coupler (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // process image toward the terminal
  esp_image_if.coupler img
);
  import esp_pkg::*;

  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [7:0] ch0_ctl_q;
  logic [15:0] ch0_dout_q;
  logic [7:0] ch1_ctl_q;
  logic [15:0] ch1_dout_q;
  logic [7:0] ch0_stat_q;
  logic [15:0] ch0_din_q;
  logic [7:0] ch1_stat_q;
  logic [15:0] ch1_din_q;
  logic [31:0] rdata_d;
  logic [31:0] hrdata_q;

  // address phase capture; single word transfers only, hsize unused
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready) begin
      dp_wr_q <= hsel && htrans[1] && hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  // image output registers written in the data phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch0_ctl_q <= ESP_BYTE_RST;
      ch0_dout_q <= ESP_WORD_RST;
      ch1_ctl_q <= ESP_BYTE_RST;
      ch1_dout_q <= ESP_WORD_RST;
    end else if (dp_wr_q) begin
      unique case (dp_addr_q)
        ESP_OFS_CH0_CTL: ch0_ctl_q <= hwdata[7:0];
        ESP_OFS_CH0_DOUT: ch0_dout_q <= hwdata[15:0];
        ESP_OFS_CH1_CTL: ch1_ctl_q <= hwdata[7:0]; // RULE13 RULE14
        ESP_OFS_CH1_DOUT: ch1_dout_q <= hwdata[15:0];
        default: ; // read-only or unmapped writes are dropped
      endcase
    end
  end

  // input image sampled every cycle so software sees the acknowledge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch0_stat_q <= ESP_BYTE_RST;
      ch0_din_q <= ESP_WORD_RST;
      ch1_stat_q <= ESP_BYTE_RST;
      ch1_din_q <= ESP_WORD_RST;
    end else begin
      ch0_stat_q <= img.ch0_stat;
      ch0_din_q <= img.ch0_din;
      ch1_stat_q <= img.ch1_stat; // RULE21
      ch1_din_q <= img.ch1_din;
    end
  end

  // read mux on the address phase so data stands in the data phase
  always_comb begin
    rdata_d = ESP_WORD32_RST;
    unique case (haddr[7:0])
      ESP_OFS_CH0_CTL: rdata_d[7:0] = ch0_ctl_q;
      ESP_OFS_CH0_DOUT: rdata_d[15:0] = ch0_dout_q;
      ESP_OFS_CH1_CTL: rdata_d[7:0] = ch1_ctl_q;
      ESP_OFS_CH1_DOUT: rdata_d[15:0] = ch1_dout_q;
      ESP_OFS_CH0_STAT: rdata_d[7:0] = ch0_stat_q;
      ESP_OFS_CH0_DIN: rdata_d[15:0] = ch0_din_q;
      ESP_OFS_CH1_STAT: rdata_d[7:0] = ch1_stat_q;
      ESP_OFS_CH1_DIN: rdata_d[15:0] = ch1_din_q;
      default: rdata_d = ESP_WORD32_RST;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= ESP_WORD32_RST;
    end else if (hready && hsel && htrans == ESP_HTRANS_NONSEQ && !hwrite) begin
      hrdata_q <= rdata_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign img.ch0_ctl = ch0_ctl_q; // RULE3 RULE20
  assign img.ch0_dout = ch0_dout_q;
  assign img.ch1_ctl = ch1_ctl_q;
  assign img.ch1_dout = ch1_dout_q;
endmodule // esp_coupler
`default_nettype wire

// ---- logic/esp_device.sv ----
// terminal end: decodes the process image, holds parameters and the output table
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: six bytes each way, two logical channels
// RULE2: channel zero: control/status byte plus word
// RULE3: control bit7 clear means plain process data
// RULE4: process status: zero MSB, error, A, B, latch
// RULE5: channel zero returns 16-bit counter value
// RULE6: enable word is four 4-bit codes
// RULE7: no-enable resets auto, discards workpiece
// RULE8: auto code runs automatic switching
// RULE9: nozzle test pauses auto, resumes afterwards
// RULE10: force codes drive static level, pause auto
// RULE11: all four nibbles share code meanings
// RULE12: channel one accesses RAM output table
// RULE13: coupler puts index bits 0-5, write bit6
// RULE14: table bit set; its fall starts evaluation
// RULE15: status echoes index, bit7 acknowledges
// RULE16: channel one returns addressed entry
// RULE17: write stores channel one word
// RULE18: coupler loads at most sixty switch values
// RULE19: entries 0-3 counts, values from index 4
// RULE20: bit7 selects register mode on channel zero
// RULE21: write done once acknowledge is seen
// RULE22: acknowledge held while table bit set
// RULE23: reads and idle words leave table unchanged
module esp_device (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // process image toward the coupler
  esp_image_if.device img,
  // encoder side inputs
  input wire logic track_a,
  input wire logic track_b,
  input wire logic latch_in,
  input wire logic error_in,
  input wire logic [15:0] counter_value,
  // per-channel output state
  output logic [3:0] auto_run,
  output logic [3:0] nozzle_test,
  output logic [3:0] out_level,
  output logic [3:0] out_forced,
  output logic [3:0] workpiece_discard,
  // output table evaluation side
  output logic table_eval_start,
  output logic [5:0] count_ch_sel,
  input wire logic [5:0] eval_index,
  output logic [15:0] eval_entry
);
  import esp_pkg::*;

  // output table and parameter set as on-chip arrays
  // neither is reset: software loads an entry before it relies on reading it back
  logic [15:0] table_mem [ESP_TABLE_DEPTH];
  logic [15:0] param_mem [ESP_TABLE_DEPTH];

  // decoded command byte fields
  // all but tbl_bit_q are plain levels off the image; the coupler holds them between updates
  logic reg_mode;
  logic tbl_mode;
  logic reg_wr;
  logic tbl_wr;
  logic [5:0] reg_idx;
  logic [5:0] tbl_idx;
  logic tbl_bit_q;

  // registered image bytes toward the coupler
  logic [7:0] ch0_stat_q;
  logic [15:0] ch0_din_q;
  logic [7:0] ch1_stat_q;
  logic [15:0] ch1_din_q;

  // evaluation side state
  logic eval_q;
  logic [15:0] eval_entry_q;
  logic [5:0] count_sel_q;

  // a write needs the access bit as well as the write bit, so a stray write
  // bit in plain process mode never touches the parameters or the table
  function automatic logic ctl_write(input logic [7:0] ctl);
    ctl_write = ctl[ESP_REG_BIT] && ctl[ESP_WR_BIT];
  endfunction

  // control byte fields
  assign reg_mode = img.ch0_ctl[ESP_REG_BIT]; // RULE20
  assign tbl_mode = img.ch1_ctl[ESP_REG_BIT]; // RULE14
  assign reg_wr = ctl_write(img.ch0_ctl); // RULE20
  assign tbl_wr = ctl_write(img.ch1_ctl); // RULE13 RULE17
  assign reg_idx = img.ch0_ctl[ESP_IDX_LSB +: ESP_IDX_W];
  assign tbl_idx = img.ch1_ctl[ESP_IDX_LSB +: ESP_IDX_W]; // RULE13

  // four identical channels, one nibble each
  // codes only count in process mode: a register value must never act as enables
  for (genvar g = 0; g < ESP_CHANNELS; g++) begin : g_chan
    esp_chan u_chan (
      .clock(clock),
      .rst_b(rst_b),
      .code(img.ch0_dout[g*ESP_NIB_W +: ESP_NIB_W]), // RULE6 RULE11
      .code_valid(!reg_mode), // RULE3
      .auto_run_q(auto_run[g]),
      .nozzle_q(nozzle_test[g]),
      .out_level_q(out_level[g]),
      .out_forced_q(out_forced[g]),
      .discard_q(workpiece_discard[g])
    );
  end

  // parameter write: the data word carries a register value, not enables
  // no reset on ram: clearing all words would need a sweep that gains nothing
  always_ff @(posedge clock) begin
    if (reg_wr) begin
      param_mem[reg_idx] <= img.ch0_dout; // RULE20
    end
  end

  // table write only in table mode with write bit; reads never store
  // a held write command stores the same word each cycle, which is harmless
  always_ff @(posedge clock) begin
    if (tbl_wr) begin
      table_mem[tbl_idx] <= img.ch1_dout; // RULE12 RULE17 RULE23
    end
  end

  // channel zero status and word back to the coupler
  // both are registered, so the coupler sees each change one edge late
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch0_stat_q <= ESP_BYTE_RST;
      ch0_din_q <= ESP_WORD_RST;
    end else if (reg_mode) begin
      // echo address and register flag as acknowledge
      // a write returns the word being stored, a read the addressed parameter
      ch0_stat_q <= img.ch0_ctl; // RULE20 RULE21
      ch0_din_q <= img.ch0_ctl[ESP_WR_BIT] ? img.ch0_dout : param_mem[reg_idx];
    end else begin
      // process mode: live input levels and the counter, one edge behind
      // clear first so the access bit and the reserved bits read zero
      ch0_stat_q <= ESP_BYTE_RST;
      ch0_stat_q[ESP_ERR_BIT] <= error_in; // RULE4
      ch0_stat_q[ESP_A_BIT] <= track_a; // RULE4
      ch0_stat_q[ESP_B_BIT] <= track_b; // RULE4
      ch0_stat_q[ESP_LATCH_BIT] <= latch_in; // RULE4
      ch0_din_q <= counter_value; // RULE5
    end
  end

  // channel one acknowledge holds while the table bit stays set
  // the acknowledge is a level, not a pulse, so a slow coupler cannot miss it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch1_stat_q <= ESP_BYTE_RST;
      ch1_din_q <= ESP_WORD_RST;
    end else if (tbl_mode) begin
      // bit 6 is free and reads zero, so software may compare the whole byte
      ch1_stat_q <= ESP_BYTE_RST;
      ch1_stat_q[ESP_IDX_LSB +: ESP_IDX_W] <= tbl_idx; // RULE15 RULE22
      ch1_stat_q[ESP_REG_BIT] <= 1'b1; // RULE15 RULE21 RULE22
      // a write returns the word being stored, a read the stored entry
      ch1_din_q <= img.ch1_ctl[ESP_WR_BIT] ? img.ch1_dout : table_mem[tbl_idx]; // RULE16
    end else begin
      // nothing echoed while idle, so a stale index cannot pose as an acknowledge
      ch1_stat_q <= ESP_BYTE_RST; // RULE22
      ch1_din_q <= ESP_WORD_RST; // RULE23
    end
  end

  // falling edge of the table bit starts table evaluation
  // the previous level is kept so a fall is seen whatever the spacing
  // limitation: the evaluator must accept a new start on every fall it is given
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tbl_bit_q <= 1'b0;
      eval_q <= 1'b0;
    end else begin
      tbl_bit_q <= tbl_mode;
      eval_q <= tbl_bit_q && !tbl_mode; // RULE14
    end
  end

  // evaluation read port; layout counts at 0-3 and values from index 4
  // one cycle of read latency; each channel's values follow the previous ones
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eval_entry_q <= ESP_WORD_RST;
      count_sel_q <= 6'h00;
    end else begin
      eval_entry_q <= table_mem[eval_index]; // RULE19
      count_sel_q <= 6'(ESP_COUNT_ENTRIES); // RULE19
    end
  end

  // channel zero back toward the coupler
  assign img.ch0_stat = ch0_stat_q; // RULE1 RULE2
  assign img.ch0_din = ch0_din_q; // RULE2

  // channel one back toward the coupler
  assign img.ch1_stat = ch1_stat_q; // RULE15
  assign img.ch1_din = ch1_din_q; // RULE16

  // evaluation side, all straight from flip-flops
  assign table_eval_start = eval_q; // RULE14
  assign eval_entry = eval_entry_q;
  assign count_ch_sel = count_sel_q; // RULE19
endmodule // esp_device
`default_nettype wire

// ---- logic/esp_image_if.sv ----
// cyclic process image exchanged between coupler and terminal
`timescale 1ns/100ps
`default_nettype none
interface esp_image_if;
  // coupler output image
  logic [7:0] ch0_ctl;
  logic [15:0] ch0_dout;
  logic [7:0] ch1_ctl;
  logic [15:0] ch1_dout;
  // coupler input image
  logic [7:0] ch0_stat;
  logic [15:0] ch0_din;
  logic [7:0] ch1_stat;
  logic [15:0] ch1_din;
  modport device (input ch0_ctl, ch0_dout, ch1_ctl, ch1_dout,
    output ch0_stat, ch0_din, ch1_stat, ch1_din);
  modport coupler (output ch0_ctl, ch0_dout, ch1_ctl, ch1_dout,
    input ch0_stat, ch0_din, ch1_stat, ch1_din);
endinterface
`default_nettype wire

// ---- logic/esp_pkg.sv ----
// shared constants and types for the encoder switch process-data port
package esp_pkg;
  // process image layout
  localparam int ESP_IMAGE_BYTES = 6;
  localparam int ESP_IDX_W = 6;
  localparam int ESP_TABLE_DEPTH = 64;
  localparam int ESP_MAX_SWITCH_VALUES = 60;
  localparam int ESP_COUNT_ENTRIES = 4;
  localparam int ESP_CHANNELS = 4;
  localparam int ESP_NIB_W = 4;
  // control and status byte fields
  localparam int ESP_REG_BIT = 7;
  localparam int ESP_WR_BIT = 6;
  localparam int ESP_IDX_LSB = 0;
  localparam int ESP_ERR_BIT = 6;
  localparam int ESP_A_BIT = 2;
  localparam int ESP_B_BIT = 1;
  localparam int ESP_LATCH_BIT = 0;
  // enable codes per output channel nibble
  localparam logic [3:0] ESP_CODE_NONE = 4'h0;
  localparam logic [3:0] ESP_CODE_AUTO = 4'h1;
  localparam logic [3:0] ESP_CODE_HIGH = 4'h2;
  localparam logic [3:0] ESP_CODE_LOW = 4'h3;
  localparam logic [3:0] ESP_CODE_NOZZLE = 4'h7;
  // reset values
  localparam logic [7:0] ESP_BYTE_RST = 8'h00;
  localparam logic [15:0] ESP_WORD_RST = 16'h0000;
  // controller register byte offsets on the ahb-lite side
  localparam logic [7:0] ESP_OFS_CH0_CTL = 8'h00;
  localparam logic [7:0] ESP_OFS_CH0_DOUT = 8'h04;
  localparam logic [7:0] ESP_OFS_CH1_CTL = 8'h08;
  localparam logic [7:0] ESP_OFS_CH1_DOUT = 8'h0c;
  localparam logic [7:0] ESP_OFS_CH0_STAT = 8'h10;
  localparam logic [7:0] ESP_OFS_CH0_DIN = 8'h14;
  localparam logic [7:0] ESP_OFS_CH1_STAT = 8'h18;
  localparam logic [7:0] ESP_OFS_CH1_DIN = 8'h1c;
  localparam logic [1:0] ESP_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ESP_WORD32_RST = 32'h0000_0000;
  // per-channel output mode
  typedef enum logic [2:0] {ESP_MODE_OFF, ESP_MODE_AUTO, ESP_MODE_NOZZLE,
    ESP_MODE_HIGH, ESP_MODE_LOW} esp_mode_t;
  // decode one enable nibble; unknown codes count as no enable
  function automatic esp_mode_t esp_decode(input logic [3:0] code);
    unique case (code)
      ESP_CODE_AUTO: esp_decode = ESP_MODE_AUTO;
      ESP_CODE_NOZZLE: esp_decode = ESP_MODE_NOZZLE;
      ESP_CODE_HIGH: esp_decode = ESP_MODE_HIGH;
      ESP_CODE_LOW: esp_decode = ESP_MODE_LOW;
      default: esp_decode = ESP_MODE_OFF;
    endcase
  endfunction
endpackage

// ---- testbench/encoder_switch_process_data_port_tb_top.sv ----
// testbench: coupler and terminal joined by the image, driven over ahb-lite
`timescale 1ns/100ps
`default_nettype none
module encoder_switch_process_data_port_tb_top;
  import esp_pkg::*;
  logic clock, rst_b, hsel, hwrite, track_a, track_b, latch_in, error_in;
  logic hreadyout, hresp, table_eval_start;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] counter_value, eval_entry, v, en;
  logic [5:0] count_ch_sel, eval_index, idx;
  logic [3:0] auto_run, nozzle_test, out_level, out_forced, workpiece_discard;
  int bad_count, n_compared, seed, n, cd[4], armed[4], disc_exp[4], disc_seen[4];
  int seq[$] = '{1, 7, 1, 0, 2, 3, 0, 5, 1, 5};
  int tbl[64];
  esp_image_if img ();
  esp_coupler i_esp_coupler (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .img(img.coupler));
  esp_device i_esp_device (.clock(clock), .rst_b(rst_b), .img(img.device), .track_a(track_a),
    .track_b(track_b), .latch_in(latch_in), .error_in(error_in), .counter_value(counter_value),
    .auto_run(auto_run), .nozzle_test(nozzle_test), .out_level(out_level),
    .out_forced(out_forced), .workpiece_discard(workpiece_discard),
    .table_eval_start(table_eval_start), .count_ch_sel(count_ch_sel),
    .eval_index(eval_index), .eval_entry(eval_entry));
  esp_image_assertions i_esp_image_assertions (.clock(clock), .rst_b(rst_b),
    .ch0_ctl(img.ch0_ctl), .ch0_dout(img.ch0_dout), .ch1_ctl(img.ch1_ctl),
    .ch1_dout(img.ch1_dout), .ch0_stat(img.ch0_stat), .ch0_din(img.ch0_din),
    .ch1_stat(img.ch1_stat), .ch1_din(img.ch1_din));
  // 100 mhz clock
  always #5 clock = ~clock;
  // count discard pulses per channel; they last one cycle only
  always @(posedge clock) begin
    for (int g = 0; g < 4; g++) begin
      if (workpiece_discard[g] === 1'b1) disc_seen[g]++;
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bchk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    @(posedge clock);
    for (int k = 0; hreadyout !== 1'b1; k++) begin
      if (k == 50) begin
        bad_count++;
        stop_test();
      end
      @(posedge clock);
    end
  endtask
  // one single ahb-lite transfer; read data lands in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= ESP_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  initial begin
    {clock, rst_b, hsel, hwrite, track_a, track_b, latch_in, error_in} = '0;
    {haddr, hwdata, htrans, counter_value, eval_index} = '0;
    hsize = 3'h2;
    seed = 23;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    // register mode: control first so the word never reaches the enables
    ahb(1'b1, ESP_OFS_CH0_CTL, 32'h0000_00df);
    ahb(1'b1, ESP_OFS_CH0_DOUT, 32'h0000_1235);
    repeat (3) @(posedge clock);
    rchk("reg status", ESP_OFS_CH0_STAT, 32'h0000_00df);
    rchk("reg echo", ESP_OFS_CH0_DIN, 32'h0000_1235);
    chk("enables in reg mode", 32'h0, {28'h0, auto_run | out_forced | nozzle_test});
    ahb(1'b1, ESP_OFS_CH0_DOUT, 32'h0);
    ahb(1'b1, ESP_OFS_CH0_CTL, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    bchk("okay response", 1'b0, hresp);
    $display("test register mode done");
    // process status and counter follow the encoder inputs
    for (int i = 0; i < 4; i++) begin
      {track_a, track_b, latch_in, error_in} <= 4'($random(seed));
      counter_value <= 16'($random(seed));
      repeat (3) @(posedge clock);
      rchk("status", ESP_OFS_CH0_STAT, {25'h0, error_in, 3'h0, track_a, track_b, latch_in});
      rchk("counter", ESP_OFS_CH0_DIN, {16'h0, counter_value});
    end
    $display("test status done");
    // each channel walks the code list from its own offset
    for (int k = 0; k < 10; k++) begin
      for (int g = 0; g < 4; g++) begin
        cd[g] = seq[(k + g) % 10];
        if (cd[g] == 1) armed[g] = 1;
        else if (cd[g] == 0 || cd[g] == 5) begin
          disc_exp[g] += armed[g];
          armed[g] = 0;
        end
        en[4*g +: 4] = 4'(cd[g]);
      end
      ahb(1'b1, ESP_OFS_CH0_DOUT, {16'h0, en});
      repeat (3) @(posedge clock);
      for (int g = 0; g < 4; g++) begin
        bchk("auto", cd[g] == 1, auto_run[g]);
        bchk("nozzle", cd[g] == 7, nozzle_test[g]);
        bchk("forced", cd[g] == 2 || cd[g] == 3, out_forced[g]);
        if (cd[g] == 2 || cd[g] == 3) bchk("level", cd[g] == 2, out_level[g]);
      end
    end
    for (int g = 0; g < 4; g++) chk("discards", disc_exp[g], disc_seen[g]);
    $display("test channels done");
    // table write, read back with a different word, then evaluation
    for (int i = 0; i < 6; i++) begin
      idx = (i < 2) ? 6'(i) : 6'($random(seed));
      v = 16'($random(seed));
      tbl[idx] = v;
      ahb(1'b1, ESP_OFS_CH1_DOUT, {16'h0, v});
      ahb(1'b1, ESP_OFS_CH1_CTL, {24'h0, 2'b11, idx});
      r = 32'h0;
      for (int k = 0; k < 20 && r[7] !== 1'b1; k++) ahb(1'b0, ESP_OFS_CH1_STAT, 32'h0);
      chk("ack", {24'h0, 2'b10, idx}, r);
      rchk("written", ESP_OFS_CH1_DIN, {16'h0, v});
      ahb(1'b1, ESP_OFS_CH1_CTL, {24'h0, 2'b10, idx});
      ahb(1'b1, ESP_OFS_CH1_DOUT, {16'h0, ~v});
      eval_index <= idx;
      repeat (3) @(posedge clock);
      rchk("read", ESP_OFS_CH1_DIN, {16'h0, 16'(tbl[idx])});
      chk("eval entry", {16'h0, 16'(tbl[idx])}, {16'h0, eval_entry});
      ahb(1'b1, ESP_OFS_CH1_CTL, 32'h0);
      n = 0;
      for (int k = 0; k < 6; k++) begin
        @(posedge clock);
        n += int'(table_eval_start === 1'b1);
      end
      chk("eval starts", 32'h1, n);
      rchk("ack cleared", ESP_OFS_CH1_STAT, 32'h0);
    end
    chk("first value index", 32'h4, {26'h0, count_ch_sel});
    $display("test table done");
    stop_test();
  end
endmodule // encoder_switch_process_data_port_tb_top
`default_nettype wire

// ---- testbench/esp_image_assertions.sv ----
// concurrent checks on the process image between coupler and terminal
`timescale 1ns/100ps
`default_nettype none
module esp_image_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // coupler output image
  input wire logic [7:0] ch0_ctl,
  input wire logic [15:0] ch0_dout,
  input wire logic [7:0] ch1_ctl,
  input wire logic [15:0] ch1_dout,
  // coupler input image
  input wire logic [7:0] ch0_stat,
  input wire logic [15:0] ch0_din,
  input wire logic [7:0] ch1_stat,
  input wire logic [15:0] ch1_din
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // a table write followed at once by a read of the same slot
  sequence s_wr;
    ch1_ctl[7:6] == 2'b11;
  endsequence
  sequence s_rd_same;
    ch1_ctl[7:6] == 2'b10 && ch1_ctl[5:0] == $past(ch1_ctl[5:0]);
  endsequence
  property p_st0_proc;
    !ch0_ctl[7] |=> !ch0_stat[7] && ch0_stat[5:3] == 3'h0;
  endproperty
  a_st0_proc: assert property (p_st0_proc) else $error("bad process status");
  property p_reg_stat;
    ch0_ctl[7] |=> ch0_stat == $past(ch0_ctl);
  endproperty
  a_reg_stat: assert property (p_reg_stat) else $error("bad register status");
  property p_reg_echo;
    ch0_ctl[7:6] == 2'b11 |=> ch0_din == $past(ch0_dout);
  endproperty
  a_reg_echo: assert property (p_reg_echo) else $error("bad register echo");
  property p_ack;
    ch1_ctl[7] |=> ch1_stat[7] && ch1_stat[5:0] == $past(ch1_ctl[5:0]);
  endproperty
  a_ack: assert property (p_ack) else $error("bad table acknowledge");
  property p_ack_clr;
    !ch1_ctl[7] |=> ch1_stat == 8'h00;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("acknowledge held");
  property p_wr_echo;
    s_wr |=> ch1_din == $past(ch1_dout);
  endproperty
  a_wr_echo: assert property (p_wr_echo) else $error("bad write echo");
  property p_idle_word;
    !ch1_ctl[7] |=> ch1_din == 16'h0000;
  endproperty
  a_idle_word: assert property (p_idle_word) else $error("table word not idle");
  property p_rd_after_wr;
    s_wr ##1 s_rd_same |=> ch1_din == $past(ch1_dout, 2);
  endproperty
  a_rd_after_wr: assert property (p_rd_after_wr) else $error("entry not stored");
endmodule // esp_image_assertions
`default_nettype wire
